// ---- rtl/sris_sequencer.sv ----
/*
 * Reset and interrupt sequencer: collects reset sources, drives the
 * open-drain reset pin, records causes, times stop recovery and
 * arbitrates interrupts at instruction boundaries. AXI4-Lite slave.
 * Assumes a single 40 MHz clock and synchronous inputs.
 */
// Implementation choices: the register addresses and register access over AXI4-Lite.
`include "sris_cfg.svh"
`default_nettype none
module sris_sequencer
   import sris_pkg::*;
#(
   parameter int NUM_IRQ = 21,
   parameter int LONG_DELAY = `SRIS_LONG_DELAY
) (
   input wire logic CLOCK_IN,
   input wire logic RESET_N_IN,
   input wire logic REF_TICK_IN,
   input wire logic POR_IN,
   input wire logic LVI_IN,
   input wire logic MONITOR_ENTRY_IN,
   input wire logic [7:0] RESET_VECTOR_HI_IN,
   input wire logic [7:0] RESET_VECTOR_LO_IN,
   input wire logic STOP_EXEC_IN,
   input wire logic FETCH_VALID_IN,
   input wire logic FETCH_OPCODE_IN,
   input wire logic FETCH_UNMAPPED_IN,
   input wire logic BOUNDARY_IN,
   input wire logic CPU_IMASK_IN,
   input wire logic WAKE_IN,
   input wire logic [NUM_IRQ:1] IRQ_REQ_IN,
   output logic RESET_PIN_OUT,
   output logic RESET_PIN_OE_OUT,
   output logic CPU_RESET_OUT,
   output logic BUS_CLK_EN_OUT,
   output logic WATCHDOG_CLK_OUT,
   output logic IRQ_TAKE_OUT,
   output logic [4:0] IRQ_VECTOR_OUT,
   output logic IRQ_OUT,
   input wire logic [11:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [11:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY
);
   import sris_pkg::*;

   initial begin
      if (NUM_IRQ != 21) $error("flag layout needs 21 sources");
      if (LONG_DELAY < 64 || LONG_DELAY > 8160) $error("bad delay");
   end

   localparam logic [12:0] LONG_CNT = 13'(LONG_DELAY - 1);
   localparam logic [12:0] SHORT_CNT = 13'(`SRIS_SHORT_DELAY - 1);
   localparam logic [12:0] PIN_CNT =
      13'(LONG_DELAY + `SRIS_SHORT_DELAY - 1);
   localparam logic [12:0] REL_CNT = 13'(`SRIS_RELEASE_DELAY - 1);

   sris_state_t state_q;
   logic [1:0] ctrl_q;
   logic [`SRIS_NUM_CAUSES-1:0] cause_q;
   logic [`SRIS_NUM_EVENTS-1:0] ev_stat_q, ev_mask_q;
   logic [NUM_IRQ:1] irq_en_q;
   logic [12:0] count;
   logic cnt_clear;
   logic ilop, illegal_address_cause, monitor_entry_reset, int_reset;
   logic [`SRIS_NUM_CAUSES-1:0] cause_set;
   logic [`SRIS_NUM_EVENTS-1:0] ev_set;
   logic [NUM_IRQ:1] serviceable;
   logic [4:0] winner;
   logic any_irq;

   // ****************************************************************
   // Reset sources
   // ****************************************************************
   assign ilop = STOP_EXEC_IN && !ctrl_q[`SRIS_CTRL_STOP_EN];
   assign illegal_address_cause = FETCH_VALID_IN && FETCH_OPCODE_IN &&
                 FETCH_UNMAPPED_IN;
   assign monitor_entry_reset = MONITOR_ENTRY_IN &&
      RESET_VECTOR_HI_IN == `SRIS_BLANK_VECTOR &&
      RESET_VECTOR_LO_IN == `SRIS_BLANK_VECTOR;
   assign int_reset = state_q != SRIS_ST_PIN_LOW &&
                      (ilop || illegal_address_cause || monitor_entry_reset || LVI_IN || POR_IN);
   always_comb begin
      cause_set = '0;
      cause_set[`SRIS_CAUSE_ILOP] = ilop;
      cause_set[`SRIS_CAUSE_ILLEGAL_ADDRESS_CAUSE] = illegal_address_cause;
      cause_set[`SRIS_CAUSE_LVI] = LVI_IN;
      cause_set[`SRIS_CAUSE_MOD] = monitor_entry_reset;
      cause_set[`SRIS_CAUSE_POR] = POR_IN;
   end

   // ****************************************************************
   // Stabilisation counter
   // ****************************************************************
   assign cnt_clear = int_reset || (state_q == SRIS_ST_RUN &&
      STOP_EXEC_IN && ctrl_q[`SRIS_CTRL_STOP_EN]) ||
      (state_q == SRIS_ST_PIN_LOW && count == PIN_CNT && REF_TICK_IN) ||
      (state_q == SRIS_ST_STOP && WAKE_IN);

   sris_stab_counter #(.WIDTH(13)) u_counter (
      .CLOCK_IN(CLOCK_IN),
      .RESET_N_IN(RESET_N_IN),
      .TICK_IN(REF_TICK_IN),
      .CLEAR_IN(cnt_clear),
      .COUNT_OUT(count),
      .OVERFLOW_OUT(WATCHDOG_CLK_OUT)
   );

   // ****************************************************************
   // Sequencing state machine
   // ****************************************************************
   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         state_q <= SRIS_ST_PIN_LOW;
      end else if (int_reset) begin
         state_q <= SRIS_ST_PIN_LOW;
      end else begin
         unique case (state_q)
            SRIS_ST_RUN: begin
               if (STOP_EXEC_IN && ctrl_q[`SRIS_CTRL_STOP_EN]) begin
                  state_q <= SRIS_ST_STOP;
               end
            end
            SRIS_ST_PIN_LOW: begin
               if (REF_TICK_IN && count == PIN_CNT) begin
                  state_q <= SRIS_ST_RELEASE;
               end
            end
            SRIS_ST_RELEASE: begin
               if (REF_TICK_IN && count == REL_CNT) begin
                  state_q <= SRIS_ST_RUN;
               end
            end
            SRIS_ST_STOP: begin
               if (WAKE_IN) begin
                  state_q <= SRIS_ST_RECOVER;
               end
            end
            SRIS_ST_RECOVER: begin
               if (REF_TICK_IN && count == (ctrl_q[`SRIS_CTRL_SHORT_STOP_RECOVERY] ?
                   SHORT_CNT : LONG_CNT)) begin
                  state_q <= SRIS_ST_RUN;
               end
            end
            default: state_q <= SRIS_ST_PIN_LOW;
         endcase
      end
   end

   assign RESET_PIN_OUT = 1'b0;
   assign RESET_PIN_OE_OUT = state_q == SRIS_ST_PIN_LOW;
   assign CPU_RESET_OUT = state_q == SRIS_ST_PIN_LOW ||
                          state_q == SRIS_ST_RELEASE;
   assign BUS_CLK_EN_OUT = state_q == SRIS_ST_RUN;

   // ****************************************************************
   // Interrupt arbitration
   // ****************************************************************
   assign serviceable = IRQ_REQ_IN & irq_en_q;
   always_comb begin
      winner = 5'h00;
      for (int i = NUM_IRQ; i >= 1; i--) begin
         if (serviceable[i]) winner = 5'(i);
      end
   end
   assign any_irq = |serviceable && !CPU_IMASK_IN;

   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         IRQ_TAKE_OUT <= 1'b0;
         IRQ_VECTOR_OUT <= 5'h00;
      end else begin
         // Also taken at return boundary before next program op
         IRQ_TAKE_OUT <= BOUNDARY_IN && any_irq &&
                         state_q == SRIS_ST_RUN;
         if (BOUNDARY_IN && any_irq) IRQ_VECTOR_OUT <= winner;
      end
   end

   // ****************************************************************
   // Registers and event status
   // ****************************************************************
   // Wake done marks the last recovery tick, before the bus runs
   logic rec_done;
   assign rec_done = state_q == SRIS_ST_RECOVER && REF_TICK_IN &&
      count == (ctrl_q[`SRIS_CTRL_SHORT_STOP_RECOVERY] ? SHORT_CNT : LONG_CNT);
   assign ev_set = {IRQ_TAKE_OUT, rec_done && !int_reset,
      state_q == SRIS_ST_RELEASE && REF_TICK_IN && count == REL_CNT};
   assign IRQ_OUT = |(ev_stat_q & ev_mask_q);

   logic aw_q, w_q;
   logic [11:0] awaddr_q;
   logic [31:0] wdata_q;
   logic wr_go;
   assign S_AXI_AWREADY = !aw_q && !S_AXI_BVALID;
   assign S_AXI_WREADY = !w_q && !S_AXI_BVALID;
   assign wr_go = aw_q && w_q && !S_AXI_BVALID;

   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= 12'h000;
         wdata_q <= 32'h0000_0000;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= 2'b00;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_q <= 1'b1;
            awaddr_q <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_q <= 1'b1;
            wdata_q <= S_AXI_WSTRB[0] ? S_AXI_WDATA : 32'h0000_0000;
         end
         if (wr_go) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= (awaddr_q >= `SRIS_OFF_PEND_LOW &&
               awaddr_q <= `SRIS_OFF_IRQ_EN && awaddr_q[1:0] == 2'b00) ?
               2'b00 : 2'b10;
         end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
      end
   end

   logic wr_lane;
   assign wr_lane = wr_go;
   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         ctrl_q <= `SRIS_CTRL_RESET;
         ev_mask_q <= '0;
         irq_en_q <= '0;
      end else if (wr_lane) begin
         // Pending registers have no write path
         unique case (awaddr_q)
            `SRIS_OFF_CTRL: ctrl_q <= wdata_q[1:0];
            `SRIS_OFF_IRQ_MASK:
               ev_mask_q <= wdata_q[`SRIS_NUM_EVENTS-1:0];
            `SRIS_OFF_IRQ_EN: irq_en_q <= wdata_q[NUM_IRQ-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         ev_stat_q <= '0;
         cause_q <= '0;
      end else begin
         // Set wins over write-one-to-clear
         if (wr_lane && awaddr_q == `SRIS_OFF_IRQ_STAT) begin
            ev_stat_q <= (ev_stat_q & ~wdata_q[`SRIS_NUM_EVENTS-1:0])
                         | ev_set;
         end else begin
            ev_stat_q <= ev_stat_q | ev_set;
         end
         if (wr_lane && awaddr_q == `SRIS_OFF_CAUSE) begin
            cause_q <= (cause_q & ~wdata_q[`SRIS_NUM_CAUSES-1:0]) |
                       cause_set;
         end else if (|cause_set && state_q != SRIS_ST_PIN_LOW) begin
            cause_q <= cause_set;
         end else begin
            cause_q <= cause_q | cause_set;
         end
      end
   end

   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0000_0000;
         S_AXI_RRESP <= 2'b00;
      end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RRESP <= 2'b00;
         unique case (S_AXI_ARADDR)
            `SRIS_OFF_PEND_LOW: S_AXI_RDATA <=
               {24'h0, IRQ_REQ_IN[6:1], 2'b00};
            `SRIS_OFF_PEND_MID: S_AXI_RDATA <=
               {24'h0, IRQ_REQ_IN[14:7]};
            `SRIS_OFF_PEND_HIGH: S_AXI_RDATA <=
               {25'h0, IRQ_REQ_IN[21:15]};
            `SRIS_OFF_CAUSE: S_AXI_RDATA <= {27'h0, cause_q};
            `SRIS_OFF_CTRL: S_AXI_RDATA <= {30'h0, ctrl_q};
            `SRIS_OFF_IRQ_STAT: S_AXI_RDATA <= {29'h0, ev_stat_q};
            `SRIS_OFF_IRQ_MASK: S_AXI_RDATA <= {29'h0, ev_mask_q};
            `SRIS_OFF_IRQ_EN: S_AXI_RDATA <= {11'h0, irq_en_q};
            default: begin
               S_AXI_RDATA <= 32'h0000_0000;
               S_AXI_RRESP <= 2'b10;
            end
         endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
         S_AXI_RVALID <= 1'b0;
      end
   end
   assign S_AXI_ARREADY = !S_AXI_RVALID;

   // ****************************************************************
   // Checks
   // ****************************************************************
   AST_ILOP_PIN: assert property (@(posedge CLOCK_IN)
      disable iff (!RESET_N_IN)
      STOP_EXEC_IN && !ctrl_q[`SRIS_CTRL_STOP_EN] |=> RESET_PIN_OE_OUT)
      else $error("disabled stop did not reset");
   AST_PIN_ALL: assert property (@(posedge CLOCK_IN)
      disable iff (!RESET_N_IN)
      (monitor_entry_reset || LVI_IN || POR_IN) |=> RESET_PIN_OE_OUT)
      else $error("internal reset left pin free");
   AST_ILLEGAL_ADDRESS_CAUSE_CAUSE: assert property (@(posedge CLOCK_IN)
      disable iff (!RESET_N_IN)
      illegal_address_cause |=> cause_q[`SRIS_CAUSE_ILLEGAL_ADDRESS_CAUSE] && RESET_PIN_OE_OUT)
      else $error("opcode fetch fault not recorded");
   AST_DATA_FETCH: assert property (@(posedge CLOCK_IN)
      disable iff (!RESET_N_IN)
      state_q == SRIS_ST_RUN && !FETCH_OPCODE_IN && !ilop && !monitor_entry_reset
      && !LVI_IN && !POR_IN |=> !RESET_PIN_OE_OUT)
      else $error("data fetch caused reset");
   AST_MONITOR_ENTRY_RESET: assert property (@(posedge CLOCK_IN)
      disable iff (!RESET_N_IN)
      monitor_entry_reset |=> cause_q[`SRIS_CAUSE_MOD])
      else $error("monitor entry not recorded");
   AST_STOP_CLEAR: assert property (@(posedge CLOCK_IN)
      disable iff (!RESET_N_IN)
      state_q == SRIS_ST_RUN && STOP_EXEC_IN &&
      ctrl_q[`SRIS_CTRL_STOP_EN] |=> count == 13'h0000)
      else $error("stop did not clear counter");
   AST_NO_BUS_STOP: assert property (@(posedge CLOCK_IN)
      disable iff (!RESET_N_IN)
      state_q == SRIS_ST_RECOVER |-> !BUS_CLK_EN_OUT)
      else $error("bus clock during recovery");
   AST_SHORT_REC: assert property (@(posedge CLOCK_IN)
      disable iff (!RESET_N_IN)
      state_q == SRIS_ST_RECOVER && REF_TICK_IN && !int_reset &&
      ctrl_q[`SRIS_CTRL_SHORT_STOP_RECOVERY] && count == SHORT_CNT
      |=> state_q == SRIS_ST_RUN)
      else $error("short recovery wrong length");
   AST_MASKED: assert property (@(posedge CLOCK_IN)
      disable iff (!RESET_N_IN)
      CPU_IMASK_IN || !BOUNDARY_IN |=> !IRQ_TAKE_OUT)
      else $error("interrupt taken while masked");
   AST_LOW_ZERO: assert property (@(posedge CLOCK_IN)
      disable iff (!RESET_N_IN)
      S_AXI_RVALID && $past(S_AXI_ARADDR) == `SRIS_OFF_PEND_LOW &&
      $past(S_AXI_ARVALID && S_AXI_ARREADY) |-> S_AXI_RDATA[1:0] == 2'b00)
      else $error("low pending bits 1:0 set");
   COV_LVI: cover property (@(posedge CLOCK_IN) LVI_IN);
   COV_STOP: cover property (@(posedge CLOCK_IN)
      state_q == SRIS_ST_RECOVER ##1 state_q == SRIS_ST_RUN);
   COV_IRQ: cover property (@(posedge CLOCK_IN) IRQ_TAKE_OUT);
endmodule : sris_sequencer
`default_nettype wire

// ---- rtl/sris_cfg.svh ----
/*
 * Constants of the reset and interrupt sequencer: register offsets,
 * field positions, reset values and timing counts.
 * Assumes inclusion by bare name from the rtl/ folder.
 */
`ifndef SRIS_CFG_SVH
`define SRIS_CFG_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define SRIS_OFF_PEND_LOW 12'h004
`define SRIS_OFF_PEND_MID 12'h008
`define SRIS_OFF_PEND_HIGH 12'h00c
`define SRIS_OFF_CAUSE 12'h010
`define SRIS_OFF_CTRL 12'h014
`define SRIS_OFF_IRQ_STAT 12'h018
`define SRIS_OFF_IRQ_MASK 12'h01c
`define SRIS_OFF_IRQ_EN 12'h020

// ****************************************************************
// Fields
// ****************************************************************
`define SRIS_CTRL_STOP_EN 0
`define SRIS_CTRL_SHORT_STOP_RECOVERY 1
`define SRIS_CTRL_RESET 2'b00
`define SRIS_CAUSE_ILOP 0
`define SRIS_CAUSE_ILLEGAL_ADDRESS_CAUSE 1
`define SRIS_CAUSE_LVI 2
`define SRIS_CAUSE_MOD 3
`define SRIS_CAUSE_POR 4
`define SRIS_NUM_CAUSES 5
`define SRIS_PEND_LOW_LSB 2
`define SRIS_EV_RESET 0
`define SRIS_EV_WAKE 1
`define SRIS_EV_VECTOR 2
`define SRIS_NUM_EVENTS 3

// ****************************************************************
// Timing counts, in stabilisation-counter ticks, and the blank reset vector byte
// ****************************************************************
`define SRIS_LONG_DELAY 4096
`define SRIS_SHORT_DELAY 32
`define SRIS_RELEASE_DELAY 32
`define SRIS_BLANK_VECTOR 8'hff

`endif

// ---- rtl/sris_pkg.sv ----
/*
 * Types shared by the reset and interrupt sequencer files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package sris_pkg;
   typedef enum logic [2:0] {
      SRIS_ST_RUN = 3'b000,
      SRIS_ST_PIN_LOW = 3'b001,
      SRIS_ST_RELEASE = 3'b010,
      SRIS_ST_STOP = 3'b011,
      SRIS_ST_RECOVER = 3'b100
   } sris_state_t;
endpackage : sris_pkg
`default_nettype wire

// ---- rtl/sris_stab_counter.sv ----
/*
 * Stabilisation counter: free 13-bit counter that advances on each
 * tick enable and can be cleared. Its carry out is a one-cycle pulse.
 * Assumes the tick enable marks the falling reference clock edge.
 */
`default_nettype none
module sris_stab_counter #(
   parameter int WIDTH = 13
) (
   input wire logic CLOCK_IN,
   input wire logic RESET_N_IN,
   input wire logic TICK_IN,
   input wire logic CLEAR_IN,
   output logic [WIDTH-1:0] COUNT_OUT,
   output logic OVERFLOW_OUT
);
   initial begin
      if (WIDTH < 13) $error("counter too narrow for delays");
   end

   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         COUNT_OUT <= '0;
      end else if (CLEAR_IN) begin
         COUNT_OUT <= '0;
      end else if (TICK_IN) begin
         COUNT_OUT <= COUNT_OUT + 1'b1;
      end
   end

   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         OVERFLOW_OUT <= 1'b0;
      end else begin
         OVERFLOW_OUT <= TICK_IN && !CLEAR_IN && (&COUNT_OUT);
      end
   end
endmodule : sris_stab_counter
`default_nettype wire

// ---- verif/sris_cpu_model.sv ----
/* CPU core and interrupt sources facing the sequencer.
   Assumes the bench loads requests and sets run and gap. */
`default_nettype none
module sris_cpu_model (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic run_in,
   input wire logic [3:0] gap_in,
   input wire logic load_in,
   input wire logic [21:1] req_in,
   input wire logic cpu_reset_in,
   input wire logic bus_clk_en_in,
   input wire logic take_in,
   input wire logic [4:0] vec_in,
   output logic ref_tick_out,
   output logic boundary_out,
   output logic [21:1] req_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt_q;
   // ********
   // Reference ticks, instruction ends, service
   // ********
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ref_tick_out <= 1'h0;
      end else begin
         ref_tick_out <= ~ref_tick_out;
      end
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_q <= 4'h0;
         boundary_out <= 1'h0;
         req_out <= '0;
      end else begin
         boundary_out <= 1'h0;
         cnt_q <= cnt_q + 4'h1;
         if (load_in) begin
            req_out <= req_in;
         end
         if (take_in) begin
            // Routine clears the served flag, vector fetch stalls
            req_out[vec_in] <= 1'h0;
            cnt_q <= 4'h0;
         end else if (cnt_q >= gap_in && run_in && bus_clk_en_in &&
                      !cpu_reset_in) begin
            boundary_out <= 1'h1;
            cnt_q <= 4'h0;
         end
      end
   end
endmodule : sris_cpu_model
`default_nettype wire

// ---- verif/test_system_reset_and_interrupt_sequencer.sv ----
/* Self-checking bench of the reset and interrupt sequencer.
   Assumes the CPU model and the rtl header and package. */
`include "sris_cfg.svh"
`default_nettype none
module test_system_reset_and_interrupt_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LDLY = 64;
   logic clk = 1'h0, rst_n = 1'h0, por = 1'h0, low_voltage_cause = 1'h0, mon = 1'h0;
   logic stp = 1'h0, wake = 1'h0, fv = 1'h0, fo = 1'h0, fu = 1'h0;
   logic imask = 1'h1, run = 1'h0, load = 1'h0, a;
   logic [7:0] vhi = 8'h5a, vlo = 8'h5a;
   logic [3:0] gap = 4'h3;
   logic [21:1] ldreq = '0;
   logic [11:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, r, seed = 32'h97447aea;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic arvalid = 1'h0, rready = 1'h0;
   wire logic tick, bnd, pin, oe, crst, bclk, wdog, take, irq, rst_pin;
   wire logic awready, wready, bvalid, arready, rvalid;
   wire logic [21:1] req;
   wire logic [4:0] vec;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   logic [33:0] exp_q[$];
   logic [4:0] vec_q[$];
   int error_cnt = 0, checked = 0, takes = 0, n;
   // Pull-up on the open-drain reset pin
   assign rst_pin = oe ? pin : 1'h1;
   always #12.5 clk = ~clk;
   sris_sequencer #(.LONG_DELAY(LDLY)) u_dut (
      .CLOCK_IN(clk), .RESET_N_IN(rst_n), .REF_TICK_IN(tick),
      .POR_IN(por), .LVI_IN(low_voltage_cause), .MONITOR_ENTRY_IN(mon),
      .RESET_VECTOR_HI_IN(vhi), .RESET_VECTOR_LO_IN(vlo),
      .STOP_EXEC_IN(stp), .FETCH_VALID_IN(fv), .FETCH_OPCODE_IN(fo),
      .FETCH_UNMAPPED_IN(fu), .BOUNDARY_IN(bnd), .CPU_IMASK_IN(imask),
      .WAKE_IN(wake), .IRQ_REQ_IN(req), .RESET_PIN_OUT(pin),
      .RESET_PIN_OE_OUT(oe), .CPU_RESET_OUT(crst), .BUS_CLK_EN_OUT(bclk),
      .WATCHDOG_CLK_OUT(wdog), .IRQ_TAKE_OUT(take), .IRQ_VECTOR_OUT(vec),
      .IRQ_OUT(irq), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
      .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready));
   sris_cpu_model u_cpu (
      .clk_in(clk), .rst_n_in(rst_n), .run_in(run), .gap_in(gap),
      .load_in(load), .req_in(ldreq), .cpu_reset_in(crst),
      .bus_clk_en_in(bclk), .take_in(take), .vec_in(vec),
      .ref_tick_out(tick), .boundary_out(bnd), .req_out(req));
   // ********
   // Helpers
   // ********
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   task automatic bad(input string m);
      error_cnt++;
      $display("wrong value at %0t: %s", $time, m);
   endtask : bad
   task automatic chk_bit(input logic g, input logic e, input string m);
      checked++;
      if (g !== e) bad(m);
   endtask : chk_bit
   task automatic chk_rd(input logic [33:0] g, input logic [33:0] e);
      checked++;
      if (g !== e) bad($sformatf("resp/data %h exp %h", g, e));
   endtask : chk_rd
   task automatic chk_vec(input logic [4:0] g, input logic [4:0] e);
      checked++;
      if (g !== e) bad($sformatf("vector %0d exp %0d", g, e));
   endtask : chk_vec
   task automatic chk_n(input int g, input int e, input string m);
      checked++;
      if (g > e + 1 || g < e - 1) bad($sformatf("%s %0d exp %0d", m, g, e));
   endtask : chk_n
   task automatic wr(input logic [11:0] ad, input logic [31:0] d,
                     input logic [1:0] e);
      awaddr <= ad;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (bvalid !== 1'h1);
      bready <= 1'h0;
      chk_rd({bresp, 32'h0}, {e, 32'h0});
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [11:0] ad, input logic [33:0] e);
      exp_q.push_back(e);
      araddr <= ad;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'h0;
      end while (rvalid !== 1'h1);
      rready <= 1'h0;
      @(posedge clk);
   endtask : rd
   task automatic ldq(input logic [21:1] v);
      ldreq <= v;
      load <= 1'h1;
      @(posedge clk);
      load <= 1'h0;
   endtask : ldq
   task automatic fire(input int k);
      case (k)
         0: stp <= 1'h1;
         1: begin
            fv <= 1'h1;
            fo <= 1'h1;
            fu <= 1'h1;
         end
         2: low_voltage_cause <= 1'h1;
         3: begin
            mon <= 1'h1;
            vhi <= 8'hff;
            vlo <= 8'hff;
         end
         4: por <= 1'h1;
         5: begin
            fv <= 1'h1;
            fu <= 1'h1;
         end
         default: mon <= 1'h1;
      endcase
      @(posedge clk);
      {stp, fv, fo, fu, low_voltage_cause, mon, por} <= 7'h0;
      vhi <= 8'h5a;
      vlo <= 8'h5a;
   endtask : fire
   task automatic seq(input int c);
      int t;
      n = 0;
      t = 0;
      while (oe !== 1'h1 && t < 50) begin
         @(posedge clk);
         t++;
      end
      chk_bit(rst_pin, 1'h0, "pin not low");
      while (oe === 1'h1 && t < 9000) begin
         @(posedge clk);
         t++;
         if (tick) n++;
      end
      chk_n(n, LDLY + 32, "pin low ticks");
      n = 0;
      while (crst === 1'h1 && t < 9000) begin
         @(posedge clk);
         t++;
         if (tick) n++;
      end
      chk_n(n, 32, "release ticks");
      repeat (4) @(posedge clk);
      chk_bit(bclk, 1'h1, "bus clocks off");
      if (c >= 0) rd(`SRIS_OFF_CAUSE, {2'h0, 32'h1 << c});
      wr(`SRIS_OFF_CAUSE, 32'h1f, 2'h0);
   endtask : seq
   task automatic results();
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results
   // Scoreboard side: every answer takes the oldest note
   always @(posedge clk) begin
      if (rvalid && rready) begin
         if (exp_q.size() == 0) bad("stray read");
         else chk_rd({rresp, rdata}, exp_q.pop_front());
      end
      if (take === 1'h1) begin
         takes++;
         if (vec_q.size() == 0) bad("stray take");
         else chk_vec(vec, vec_q.pop_front());
      end
   end
   initial begin
      #2500000;
      error_cnt++;
      results();
   end
   initial begin
      repeat (2) @(posedge clk);
      chk_bit(rst_pin, 1'h0, "pin in reset");
      chk_bit(bclk, 1'h0, "bus clocks in reset");
      rst_n <= 1'h1;
      seq(-1);
      for (int k = 0; k < 7; k++) begin
         fire(k);
         if (k < 5) seq(k);
         else begin
            repeat (20) @(posedge clk);
            chk_bit(rst_pin, 1'h1, "spurious reset");
            rd(`SRIS_OFF_CAUSE, 34'h0);
         end
      end
      for (int s = 1; s >= 0; s--) begin
         wr(`SRIS_OFF_CTRL, {30'h0, s[0], 1'h1}, 2'h0);
         fire(0);
         repeat (4) @(posedge clk);
         chk_bit(bclk, 1'h0, "clocks in stop");
         wake <= 1'h1;
         @(posedge clk);
         wake <= 1'h0;
         n = 0;
         for (int t = 0; t < 2000 && bclk !== 1'h1; t++) begin
            @(posedge clk);
            if (tick) n++;
         end
         chk_n(n, s ? 32 : LDLY, "recovery ticks");
      end
      rd(`SRIS_OFF_IRQ_STAT, 34'h3);
      wr(`SRIS_OFF_IRQ_EN, 32'h1fffff, 2'h0);
      ldq(21'h114);
      imask <= 1'h0;
      repeat (20) @(posedge clk);
      imask <= 1'h1;
      run <= 1'h1;
      gap <= 4'h9;
      repeat (60) @(posedge clk);
      chk_bit(takes == 0, 1'h1, "take while masked");
      vec_q = '{5'h3, 5'h5, 5'h9};
      imask <= 1'h0;
      for (int t = 0; t < 300 && vec_q.size() > 0; t++) @(posedge clk);
      chk_bit(vec_q.size() == 0, 1'h1, "service order");
      gap <= 4'h3;
      wr(`SRIS_OFF_IRQ_EN, 32'h100, 2'h0);
      vec_q.push_back(5'h9);
      ldq(21'h102);
      repeat (40) @(posedge clk);
      chk_bit(takes == 4, 1'h1, "disabled source taken");
      wr(`SRIS_OFF_IRQ_MASK, 32'h0, 2'h0);
      repeat (2) @(posedge clk);
      a = irq;
      wr(`SRIS_OFF_IRQ_MASK, 32'h7, 2'h0);
      repeat (2) @(posedge clk);
      chk_bit(irq ^ a, 1'h1, "mask has no effect");
      wr(`SRIS_OFF_IRQ_STAT, 32'h7, 2'h0);
      repeat (2) @(posedge clk);
      chk_bit(irq, 1'h0, "irq after clear");
      rd(`SRIS_OFF_IRQ_STAT, 34'h0);
      rd(`SRIS_OFF_IRQ_MASK, 34'h7);
      wr(`SRIS_OFF_IRQ_EN, 32'h0, 2'h0);
      repeat (3) begin
         r = xs();
         ldq(r[20:0]);
         rd(`SRIS_OFF_PEND_LOW, {26'h0, r[5:0], 2'h0});
         rd(`SRIS_OFF_PEND_MID, {26'h0, r[13:6]});
         rd(`SRIS_OFF_PEND_HIGH, {27'h0, r[20:14]});
         wr(`SRIS_OFF_PEND_LOW, xs(), 2'h0);
         rd(`SRIS_OFF_PEND_LOW, {26'h0, r[5:0], 2'h0});
      end
      rd(12'h024, {2'h2, 32'h0});
      wr(12'h024, 32'h1, 2'h2);
      for (int t = 0; t < 20000 && wdog !== 1'h1; t++) @(posedge clk);
      @(posedge clk);
      n = 1;
      for (int t = 0; t < 20000 && wdog !== 1'h1; t++) begin
         @(posedge clk);
         n++;
      end
      chk_n(n, 16384, "watchdog period");
      results();
   end
endmodule : test_system_reset_and_interrupt_sequencer
`default_nettype wire
